// *** rtl/bfs_pkg.sv ***
// Shared constants of the busy and first-fault status block
package bfs_pkg;

  // Command codes served by this block
  localparam logic [7:0]  CMD_COMMON       = 8'hF0;
  localparam logic [7:0]  CMD_STATUS2      = 8'hF1;
  localparam logic [7:0]  CMD_FIRST_FAULT  = 8'hF2;
  localparam logic [7:0]  CMD_CLEAR_FAULTS = 8'h03;

  // Common status byte layout
  localparam int          COM_ALERTB_BIT   = 7;
  localparam int          COM_BUSYB_BIT    = 6;
  localparam int          COM_SHARE_BIT    = 1;
  localparam int          COM_WP_BIT       = 0;
  localparam logic [7:0]  COM_RSVD_ONES    = 8'h3C;

  // Second fault status word layout
  localparam int          ST2_SHORT_BIT    = 2;
  localparam int          ST2_AUX_BIT      = 1;
  localparam int          ST2_VINOFF_BIT   = 0;
  localparam logic [15:0] ST2_RESET        = 16'h0000;

  // First-fault record layout and codes
  localparam int          FF_PAGE_LSB      = 12;
  localparam int          FF_BITN_LSB      = 8;
  localparam logic [3:0]  FF_PAGE_GLOBAL   = 4'hF;
  localparam logic [3:0]  FF_PAGE_CH1      = 4'h1;
  localparam logic [3:0]  FF_PAGE_CH0      = 4'h0;
  localparam logic [7:0]  FF_CMD_MFR       = 8'h80;
  localparam logic [7:0]  FF_CMD_TEMP      = 8'h7D;
  localparam logic [7:0]  FF_CMD_INPUT     = 8'h7C;
  localparam logic [7:0]  FF_CMD_VOUT      = 8'h7A;
  localparam logic [7:0]  FF_CMD_NONE      = 8'h00;
  localparam logic [15:0] FF_RESET         = 16'h0000;
  localparam logic [7:0]  STAMP_RESET      = 8'h00;

  // Timing
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          SHARE_LOW_NS     = 1000;
  localparam int          SHARE_LOW_CYC    = (SHARE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// *** rtl/bfs_sync.sv ***
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module bfs_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;

  // First stage read only by the second
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule

// *** rtl/bfs_share_mon.sv ***
// Shared clock monitor: held-low detect and shared timer low byte
`timescale 1ns/10ps
module bfs_share_mon #(
  parameter int TIMER_W = 8,
  parameter int LOW_CYC = bfs_pkg::SHARE_LOW_CYC
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_share_clk,
  output logic                    o_held_low,
  output logic      [TIMER_W-1:0] o_timer
);

  localparam int CW = $clog2(LOW_CYC + 1);

  logic          share_s;
  logic          share_d_reg;
  logic [CW-1:0] low_cnt_reg;

  bfs_sync #(.W(1)) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_share_clk),
    .o_sync  (share_s)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) share_d_reg <= 1'b0;
    else          share_d_reg <= share_s;
  end

  // Timer ticks on each rising edge of the shared clock
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)                   o_timer <= '0;
    else if (share_s && !share_d_reg) o_timer <= o_timer + 1'b1;
  end

  // Low for longer than any active half period means the line is parked
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      low_cnt_reg <= '0;
      o_held_low  <= 1'b0;
    end else if (share_s) begin
      low_cnt_reg <= '0;
      o_held_low  <= 1'b0;
    end else if (low_cnt_reg != CW'(LOW_CYC)) begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end else begin
      o_held_low  <= 1'b1;
    end
  end

endmodule

// *** rtl/bfs_status.sv ***
// Common status, second fault status and first-fault record
`timescale 1ns/10ps
// How it works
// R1: While busy, only common status reads served.
// R2: Busy: NACK command byte, set busy flags.
// R3: Busy rejection pulls alert line low.
// R4: Alert field reads alert line level.
// R5: Availability field is one unless busy.
// R6: Reserved common status bits read ones.
// R7: Shared-clock field one when line held low.
// R8: Write-protect field reports pin level.
// R9: Sticky bits hold until clear or turn-on.
// R10: Alert-raising bits pull alert when set.
// R11: Global bits ignore page; others follow page.
// R12: Status word bits 15..3 read zero.
// R13: Bit 2: early turn-on, sticky, alerting.
// R14: Bit 1: live auxiliary pad drive, global.
// R15: Bit 0: input-voltage turn-off, sticky, quiet.
// R16: Record first forced-off fault regardless of logging.
// R17: Clear record on clear command or turn-on.
// R18: Snapshot shared timer low byte at fault.
// R19: Stamp resets whenever record is cleared.
// R20: Record bits 15..12 hold fault page.
// R21: Record bits 11..8 hold bit number.
// R22: Record bits 7..0 hold status command.
// R23: Held record not overwritten until cleared.
module bfs_status #(
  parameter int NCH     = 2,
  parameter int TIMER_W = 8
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_CMD_VALID,
  input  wire logic [7:0]  I_CMD_CODE,
  input  wire logic        I_BUSY,
  input  wire logic        I_PAGE,
  input  wire logic [1:0]  I_CH_ON,
  input  wire logic [1:0]  I_SHORT_CYCLE,
  input  wire logic [1:0]  I_VIN_OFF,
  input  wire logic        I_AUX_DRIVE,
  input  wire logic        I_FAULT_OFF,
  input  wire logic        I_FAULT_GLOBAL,
  input  wire logic        I_FAULT_CH,
  input  wire logic [3:0]  I_FAULT_BITN,
  input  wire logic [7:0]  I_FAULT_CMD,
  input  wire logic        I_ALERT,
  input  wire logic        I_WP,
  input  wire logic        I_SHARE_CLK,
  output logic             O_CMD_ACK,
  output logic             O_CMD_NACK,
  output logic             O_RD_HIT,
  output logic      [15:0] O_RD_DATA,
  output logic             O_BUSY_FLAG,
  output logic             O_ALERT_OE_N,
  output logic      [15:0] O_LOG_FIRST_FAULT,
  output logic      [7:0]  O_LOG_STAMP
);

  // Decoding shared by the read-hit flag and the read mux
  function automatic logic is_status_read(input logic [7:0] code);
    is_status_read = (code == bfs_pkg::CMD_COMMON) ||
                     (code == bfs_pkg::CMD_STATUS2) ||
                     (code == bfs_pkg::CMD_FIRST_FAULT);
  endfunction

  function automatic logic [3:0] page_code(input logic glob, input logic ch);
    if (glob)    page_code = bfs_pkg::FF_PAGE_GLOBAL;
    else if (ch) page_code = bfs_pkg::FF_PAGE_CH1;
    else         page_code = bfs_pkg::FF_PAGE_CH0;
  endfunction

  logic [1:0]         pin_s;
  logic               alert_s;
  logic               wp_s;
  logic               share_low;
  logic [TIMER_W-1:0] share_timer;

  logic [NCH-1:0]     ch_on_d_reg;
  logic [NCH-1:0]     ch_turn_on;
  logic               accept;
  logic               reject;
  logic               clear_cmd;
  logic [NCH-1:0]     short_reg;
  logic [NCH-1:0]     vinoff_reg;
  logic               alert_reg;
  logic               alert_next;
  logic               ff_held_reg;
  logic               ff_clear;
  logic               ff_take;
  logic [7:0]         common_byte;
  logic [15:0]        status2_word;
  logic [15:0]        rd_next;

  bfs_sync #(.W(2)) u_pin_sync (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_async ({I_ALERT, I_WP}),
    .o_sync  (pin_s)
  );

  assign alert_s = pin_s[1];
  assign wp_s    = pin_s[0];

  bfs_share_mon #(.TIMER_W(TIMER_W)) u_share (
    .i_clk       (I_CLK),
    .i_rst_n     (I_RST_N),
    .i_share_clk (I_SHARE_CLK),
    .o_held_low  (share_low),
    .o_timer     (share_timer)
  );

  // Channel off-to-on transitions
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) ch_on_d_reg <= '0;
    else          ch_on_d_reg <= I_CH_ON;
  end

  assign ch_turn_on = I_CH_ON & ~ch_on_d_reg;

  // Command acceptance
  assign accept    = I_CMD_VALID && (!I_BUSY || (I_CMD_CODE == bfs_pkg::CMD_COMMON)); // [R1]
  assign reject    = I_CMD_VALID && !accept;                                         // [R2]
  assign clear_cmd = accept && (I_CMD_CODE == bfs_pkg::CMD_CLEAR_FAULTS);

  // Address ack is the link engine's; this is the command byte answer
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_CMD_ACK  <= 1'b0;
      O_CMD_NACK <= 1'b0;
      O_RD_HIT   <= 1'b0;
    end else begin
      O_CMD_ACK  <= accept;
      O_CMD_NACK <= reject;                          // [R2]
      O_RD_HIT   <= accept && is_status_read(I_CMD_CODE);
    end
  end

  // Busy flag for status byte and word; a new rejection beats a clear
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N)       O_BUSY_FLAG <= 1'b0;
    else if (reject)    O_BUSY_FLAG <= 1'b1;          // [R2]
    else if (clear_cmd) O_BUSY_FLAG <= 1'b0;
  end

  // Sticky per-channel bits; set wins over clear
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge I_CLK) begin
        if (!I_RST_N)                           short_reg[g] <= 1'b0;
        else if (I_SHORT_CYCLE[g])              short_reg[g] <= 1'b1;  // [R13]
        else if (clear_cmd || ch_turn_on[g])    short_reg[g] <= 1'b0;  // [R9]
      end

      always_ff @(posedge I_CLK) begin
        if (!I_RST_N)                           vinoff_reg[g] <= 1'b0;
        else if (I_VIN_OFF[g])                  vinoff_reg[g] <= 1'b1; // [R15]
        else if (clear_cmd || ch_turn_on[g])    vinoff_reg[g] <= 1'b0; // [R9]
      end
    end
  endgenerate

  // Alert latch; held until a clear command, raised events win
  always_comb begin
    alert_next = alert_reg;
    if (clear_cmd)
      alert_next = 1'b0;
    if (reject)
      alert_next = 1'b1;                             // [R3]
    // Any short event, so a clear in the same cycle cannot swallow it
    if (|I_SHORT_CYCLE)
      alert_next = 1'b1;                             // [R10]
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) alert_reg <= 1'b0;
    else          alert_reg <= alert_next;
  end

  // Open drain: enable low while pulling the line
  assign O_ALERT_OE_N = ~alert_reg;

  // First-fault record; capture regardless of log enable
  assign ff_clear = clear_cmd || (|ch_turn_on);      // [R17]
  assign ff_take  = I_FAULT_OFF && !ff_held_reg;     // [R23]

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N)      ff_held_reg <= 1'b0;
    else if (ff_take)  ff_held_reg <= 1'b1;
    else if (ff_clear) ff_held_reg <= 1'b0;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_LOG_FIRST_FAULT <= bfs_pkg::FF_RESET;
    end else if (ff_take) begin                      // [R16]
      O_LOG_FIRST_FAULT <= {page_code(I_FAULT_GLOBAL, I_FAULT_CH), // [R20]
                            I_FAULT_BITN,                          // [R21]
                            I_FAULT_CMD};                          // [R22]
    end else if (ff_clear) begin
      O_LOG_FIRST_FAULT <= bfs_pkg::FF_RESET;        // [R17]
    end
  end

  // Stamp follows the record so the two never disagree
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N)      O_LOG_STAMP <= bfs_pkg::STAMP_RESET;
    else if (ff_take)  O_LOG_STAMP <= share_timer[7:0];       // [R18]
    else if (ff_clear) O_LOG_STAMP <= bfs_pkg::STAMP_RESET;   // [R19]
  end

  // Common status byte
  always_comb begin
    common_byte                          = bfs_pkg::COM_RSVD_ONES; // [R6]
    common_byte[bfs_pkg::COM_ALERTB_BIT] = alert_s;                // [R4]
    common_byte[bfs_pkg::COM_BUSYB_BIT]  = !I_BUSY;                // [R5]
    common_byte[bfs_pkg::COM_SHARE_BIT]  = share_low;              // [R7]
    common_byte[bfs_pkg::COM_WP_BIT]     = wp_s;                   // [R8]
  end

  // Second fault status word
  always_comb begin
    status2_word                         = bfs_pkg::ST2_RESET;     // [R12]
    status2_word[bfs_pkg::ST2_SHORT_BIT] = short_reg[I_PAGE];      // [R11]
    status2_word[bfs_pkg::ST2_AUX_BIT]   = I_AUX_DRIVE;            // [R14]
    status2_word[bfs_pkg::ST2_VINOFF_BIT] = vinoff_reg[I_PAGE];    // [R11]
  end

  // Read data
  always_comb begin
    rd_next = O_RD_DATA;
    if (accept && is_status_read(I_CMD_CODE)) begin
      unique case (I_CMD_CODE)
        bfs_pkg::CMD_COMMON:  rd_next = {8'h00, common_byte};
        bfs_pkg::CMD_STATUS2: rd_next = status2_word;
        default:              rd_next = O_LOG_FIRST_FAULT;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) O_RD_DATA <= 16'h0000;
    else          O_RD_DATA <= rd_next;
  end

endmodule

// *** dv/bfs_status_sva.sv ***
// Port checker for the status block
`timescale 1ns/10ps
module bfs_status_sva (
  input wire logic        I_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_CMD_VALID,
  input wire logic [7:0]  I_CMD_CODE,
  input wire logic        I_BUSY,
  input wire logic [1:0]  I_CH_ON,
  input wire logic [1:0]  I_SHORT_CYCLE,
  input wire logic        I_FAULT_OFF,
  input wire logic [3:0]  I_FAULT_BITN,
  input wire logic [7:0]  I_FAULT_CMD,
  input wire logic        O_CMD_ACK,
  input wire logic        O_CMD_NACK,
  input wire logic        O_RD_HIT,
  input wire logic [15:0] O_RD_DATA,
  input wire logic        O_BUSY_FLAG,
  input wire logic        O_ALERT_OE_N,
  input wire logic [15:0] O_LOG_FIRST_FAULT,
  input wire logic [7:0]  O_LOG_STAMP
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  logic [1:0] on_reg;
  logic       acc_clr;
  logic       ch_rise;
  always_ff @(posedge I_CLK) on_reg <= I_CH_ON;
  assign acc_clr = I_CMD_VALID && !I_BUSY && I_CMD_CODE == 8'h03;
  assign ch_rise = |(I_CH_ON & ~on_reg);
  sequence busy_rej;
    I_CMD_VALID && I_BUSY && I_CMD_CODE != 8'hF0;
  endsequence
  sequence ff_cap;
    I_FAULT_OFF && O_LOG_FIRST_FAULT == 16'h0000;
  endsequence
  ack_free_a: assert property (I_CMD_VALID && !I_BUSY |=> O_CMD_ACK && !O_CMD_NACK)
    else $error("free command not acked");
  poll_busy_a: assert property (I_CMD_VALID && I_BUSY && I_CMD_CODE == 8'hF0 |=> O_RD_HIT && !O_RD_DATA[6])
    else $error("busy poll not served");
  nack_busy_a: assert property (busy_rej |=> O_CMD_NACK && O_BUSY_FLAG && !O_CMD_ACK)
    else $error("busy command not refused");
  reject_alert_a: assert property (busy_rej |=> !O_ALERT_OE_N)
    else $error("refusal left alert free");
  alert_hold_a: assert property (!O_ALERT_OE_N && !acc_clr |=> !O_ALERT_OE_N)
    else $error("alert dropped early");
  short_alert_a: assert property (|I_SHORT_CYCLE |=> !O_ALERT_OE_N)
    else $error("short cycle gave no alert");
  common_rsvd_a: assert property (O_RD_HIT && $past(I_CMD_CODE) == 8'hF0
    |-> O_RD_DATA[15:8] == 8'h00 && O_RD_DATA[5:2] == 4'hF)
    else $error("common reserved bits wrong");
  word_rsvd_a: assert property (O_RD_HIT && $past(I_CMD_CODE) == 8'hF1 |-> O_RD_DATA[15:3] == 13'h0000)
    else $error("status word upper bits set");
  ff_clear_a: assert property (acc_clr && !I_FAULT_OFF
    |=> O_LOG_FIRST_FAULT == 16'h0000 && O_LOG_STAMP == 8'h00)
    else $error("record not cleared");
  ff_capture_a: assert property (ff_cap
    |=> O_LOG_FIRST_FAULT[11:0] == {$past(I_FAULT_BITN), $past(I_FAULT_CMD)})
    else $error("record capture wrong");
  ff_hold_a: assert property (O_LOG_FIRST_FAULT != 16'h0000 && !acc_clr && !ch_rise
    |=> $stable(O_LOG_FIRST_FAULT) && $stable(O_LOG_STAMP))
    else $error("held record changed");
endmodule
bind bfs_status bfs_status_sva chk_u (.*);

// *** dv/bfs_host.sv ***
// Host model: command bytes and shared clock
`timescale 1ns/10ps
module bfs_host (
  input  wire logic       i_clk,
  output logic            o_cmd_valid,
  output logic      [7:0] o_cmd_code,
  output logic            o_share_clk
);
  logic run;
  int   edges;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code  = 8'h00;
    o_share_clk = 1'b1;
    run         = 1'b0;
    edges       = 0;
  end
  // Stands still when stopped, 80 ns period when running
  always #40 if (run) o_share_clk = ~o_share_clk;
  // Power-up step from unknown is no real edge
  always @(posedge o_share_clk) if ($time > 0) edges++;
  task automatic share_set(input logic r, input logic lvl);
    run = r;
    if (!r) o_share_clk = lvl;
  endtask
  // One-cycle command, released code shows its inverse
  task automatic issue(input logic [7:0] c);
    @(posedge i_clk);
    #1 o_cmd_valid = 1'b1;
    o_cmd_code = c;
    @(posedge i_clk);
    #1 o_cmd_valid = 1'b0;
    o_cmd_code = ~c;
  endtask
endmodule

// *** dv/bfs_status_tb.sv ***
// Self-checking bench for the status block
`timescale 1ns/10ps
module bfs_status_tb;
  typedef struct packed {logic [3:0] w; logic [3:0] b; logic [7:0] c;
                         logic [3:0] n; logic [3:0] h; logic [15:0] d;} bfs_row_s;
  logic        clk, rst_n, busy, page, aux, f_off, f_glb, f_ch, wp, cv, share;
  logic        ack, nack, hit, bflag, oe_n;
  logic [1:0]  ch_on, short_cyc, vin_off;
  logic [3:0]  f_bitn;
  logic [7:0]  f_cmd, cc, stamp;
  logic [15:0] rd_data, log_ff, ex;
  int          failures, total_checks;
  logic [7:0]  cmds [4] = '{8'h80, 8'h7D, 8'h7C, 8'h7A};
  bfs_row_s    rows [11] = '{40'h0_0_F0_0_1_00FC, 40'h1_0_F0_0_1_00FD, 40'h0_1_F0_0_1_00BC, 40'h0_1_F1_1_0_0000,
    40'h0_1_F2_1_0_0000, 40'h0_1_03_1_0_0000, 40'h0_0_F0_0_1_007C, 40'h0_0_F1_0_1_0000,
    40'h0_0_F2_0_1_0000, 40'h0_0_03_0_0_0000, 40'h0_0_F0_0_1_00FC};
  bfs_host host_u (.i_clk(clk), .o_cmd_valid(cv), .o_cmd_code(cc), .o_share_clk(share));
  bfs_status dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_CMD_VALID(cv), .I_CMD_CODE(cc), .I_BUSY(busy), .I_PAGE(page),
    .I_CH_ON(ch_on), .I_SHORT_CYCLE(short_cyc), .I_VIN_OFF(vin_off), .I_AUX_DRIVE(aux), .I_FAULT_OFF(f_off),
    .I_FAULT_GLOBAL(f_glb), .I_FAULT_CH(f_ch), .I_FAULT_BITN(f_bitn), .I_FAULT_CMD(f_cmd), .I_ALERT(oe_n), .I_WP(wp),
    .I_SHARE_CLK(share), .O_CMD_ACK(ack), .O_CMD_NACK(nack), .O_RD_HIT(hit), .O_RD_DATA(rd_data), .O_BUSY_FLAG(bflag),
    .O_ALERT_OE_N(oe_n), .O_LOG_FIRST_FAULT(log_ff), .O_LOG_STAMP(stamp));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    host_u.issue(c);
    chk({hit, rd_data}, {1'b1, e});
  endtask
  task automatic end_sim;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, busy, page, aux, f_off, f_glb, f_ch, wp, short_cyc, vin_off, f_bitn, f_cmd} = '0;
    ch_on = 2'h3;
    failures = 0;
    total_checks = 0;
    cyc(4);
    chk({oe_n, ack, nack, hit, bflag, rd_data, log_ff, stamp}, {1'b1, 44'h0});
    rst_n = 1'b1;
    host_u.share_set(1'b1, 1'b0);
    cyc(3);
    foreach (rows[i]) begin
      wp = rows[i].w[0];
      busy = rows[i].b[0];
      cyc(4);
      host_u.issue(rows[i].c);
      chk({ack, nack, hit}, {~rows[i].n[0], rows[i].n[0], rows[i].h[0]});
      if (rows[i].h[0]) chk(rd_data, rows[i].d);
      if (rows[i].n[0]) chk({bflag, oe_n}, 2'b10);
    end
    vin_off = 2'h1;
    cyc(1);
    vin_off = 2'h0;
    aux = 1'b1;
    chk(oe_n, 1'b1);
    short_cyc = 2'h2;
    cyc(1);
    short_cyc = 2'h0;
    chk(oe_n, 1'b0);
    rd(8'hF1, 16'h0003);
    page = 1'b1;
    rd(8'hF1, 16'h0006);
    ch_on = 2'h1;
    cyc(2);
    ch_on = 2'h3;
    cyc(2);
    rd(8'hF1, 16'h0002);
    page = 1'b0;
    rd(8'hF1, 16'h0003);
    host_u.issue(8'h03);
    aux = 1'b0;
    rd(8'hF1, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      host_u.share_set(1'b0, 1'b1);
      cyc(6);
      f_glb = (i == 0);
      f_ch = i[0];
      f_bitn = 4'(i + 3);
      f_cmd = cmds[i];
      f_off = 1'b1;
      cyc(1);
      f_off = 1'b0;
      ex = {(i == 0) ? 4'hF : {3'h0, i[0]}, f_bitn, f_cmd};
      chk({log_ff, stamp}, {ex, host_u.edges[7:0]});
      f_ch = ~f_ch;
      f_off = 1'b1;
      cyc(1);
      f_off = 1'b0;
      busy = 1'b1;
      host_u.issue(8'h03);
      busy = 1'b0;
      chk(nack, 1'b1);
      rd(8'hF2, ex);
      if (i[1]) begin
        ch_on = 2'h2;
        cyc(2);
        ch_on = 2'h3;
        cyc(2);
      end else host_u.issue(8'h03);
      chk({log_ff, stamp}, 24'h0);
      host_u.share_set(1'b1, 1'b0);
      cyc(20);
    end
    host_u.issue(8'h03);
    chk(bflag, 1'b0);
    host_u.share_set(1'b0, 1'b0);
    cyc(110);
    rd(8'hF0, 16'h00FE);
    host_u.share_set(1'b1, 1'b0);
    cyc(10);
    rd(8'hF0, 16'h00FC);
    end_sim();
  end
endmodule
